// File: fast_oc_cfg_reg.sv
// Response setting register reached by its command code.
// Assumes single-cycle write and read strobes from the command decoder.
`timescale 1ns/10ps
`include "fast_oc_defines.svh"

module fast_oc_cfg_reg (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Command port
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_ack,
	// Decoded setting
	output fast_oc_pkg::resp_cfg_s cfg
);

	logic [7:0] fast_overcurrent_response_config_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic ack_r;
	wire hit;

	function automatic logic is_cfg(input logic [7:0] code);
		return code == `FOC_CFG_CMD;
	endfunction

	assign hit = is_cfg(cmd_code);

	always_ff @(posedge mclk) begin
		if (reset) begin
			fast_overcurrent_response_config_r <= `FOC_CFG_RESET;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			ack_r <= 1'b0;
		end else begin
			if (cmd_wr && hit) begin
				fast_overcurrent_response_config_r <= cmd_wdata;
			end
			// Unknown codes answer a read with zero and no acknowledge
			rdata_r <= (cmd_rd && hit) ? fast_overcurrent_response_config_r : 8'h00;
			rvalid_r <= cmd_rd;
			ack_r <= (cmd_wr || cmd_rd) && hit;
		end
	end

	assign cmd_rdata = rdata_r;
	assign cmd_rvalid = rvalid_r;
	assign cmd_ack = ack_r;
	assign cfg.response = fast_overcurrent_response_config_r[`FOC_RESP_HI:`FOC_RESP_LO];
	assign cfg.retry = fast_overcurrent_response_config_r[`FOC_RETRY_HI:`FOC_RETRY_LO];
	assign cfg.delay_exp = fast_overcurrent_response_config_r[`FOC_DELAY_HI:`FOC_DELAY_LO];

endmodule

// File: fast_oc_defines.svh
// Constants of the fast over-current fault response block.
// Assumes a 100 MHz controller clock; included by bare name.
`ifndef FAST_OC_DEFINES_SVH
`define FAST_OC_DEFINES_SVH

// ==========================================
// Register map
`define FOC_CFG_CMD 8'hCA
`define FOC_CFG_RESET 8'h00

// ==========================================
// Field positions of the response setting
`define FOC_RESP_HI 7
`define FOC_RESP_LO 6
`define FOC_RETRY_HI 5
`define FOC_RETRY_LO 3
`define FOC_DELAY_HI 2
`define FOC_DELAY_LO 0

// ==========================================
// Codes
`define FOC_RESP_IGNORE 2'h0
`define FOC_RESP_SHUT_RETRY 2'h3
`define FOC_RETRY_NONE 3'h0
`define FOC_RETRY_ALWAYS 3'h7

// ==========================================
// Timing
`define FOC_CLK_PERIOD_NS 10
`define FOC_MS_NS 1000000
`define FOC_CYCLES_PER_MS (`FOC_MS_NS / `FOC_CLK_PERIOD_NS)
`define FOC_UNIT0_MS 16'h0001
`define FOC_UNIT1_MS 16'h0004
`define FOC_UNIT2_MS 16'h0010
`define FOC_UNIT3_MS 16'h0100

`endif

// File: fast_oc_delay_timer.sv
// Delay timer: counts (time unit << exponent) milliseconds after a start pulse.
// Assumes start is a one-cycle pulse; a new start restarts the interval.
`timescale 1ns/10ps
`include "fast_oc_defines.svh"

module fast_oc_delay_timer #(
	parameter int CYCLES_PER_MS = `FOC_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic [1:0] unit_code,
	input wire logic [2:0] delay_exp,
	// Status
	output logic done
);

	logic [16:0] pre_r;
	logic [15:0] ms_left_r;
	logic running_r;
	logic done_r;
	wire ms_tick;
	wire [15:0] unit_ms;
	wire [15:0] total_ms;

	// Unit select, then 1,2,4..128 units
	assign unit_ms = (unit_code == 2'h0) ? `FOC_UNIT0_MS :
		(unit_code == 2'h1) ? `FOC_UNIT1_MS :
		(unit_code == 2'h2) ? `FOC_UNIT2_MS : `FOC_UNIT3_MS;
	assign total_ms = unit_ms << delay_exp;
	assign ms_tick = running_r && (pre_r == 17'(CYCLES_PER_MS - 1));

	always_ff @(posedge mclk) begin
		if (reset) begin
			pre_r <= 17'h00000;
			ms_left_r <= 16'h0000;
			running_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				pre_r <= 17'h00000;
				ms_left_r <= total_ms;
				running_r <= 1'b1;
			end else if (ms_tick) begin
				pre_r <= 17'h00000;
				ms_left_r <= ms_left_r - 16'h0001;
				if (ms_left_r == 16'h0001) begin
					running_r <= 1'b0;
					done_r <= 1'b1;
				end
			end else if (running_r) begin
				pre_r <= pre_r + 17'h00001;
			end
		end
	end

	assign done = done_r;

endmodule

// File: fast_oc_pkg.sv
// Types shared by the fast over-current fault response block.
// Assumes fast_oc_defines.svh supplies the numbers.
package fast_oc_pkg;

	// ==========================================
	// Decoded response setting
	typedef struct packed {
		logic [1:0] response;
		logic [2:0] retry;
		logic [2:0] delay_exp;
	} resp_cfg_s;

	// ==========================================
	// Response sequencer states
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_LIMIT = 3'b001,
		ST_OFF_WAIT = 3'b010,
		ST_RESTART = 3'b011,
		ST_HELD_OFF = 3'b100
	} resp_state_e;

endpackage

// File: fast_oc_properties.sv
// Checker for the fast over-current fault response ports.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps

module fast_oc_properties (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Sense and control
	input wire logic fast_oc_detect,
	input wire logic fault_clear,
	input wire logic commanded_off,
	input wire logic bias_ok,
	input wire logic other_fault_shutdown,
	// Outputs
	input wire logic output_enable,
	input wire logic limit_at_fast,
	input wire logic restart_strobe,
	input wire logic status_fast_oc_fault,
	input wire logic host_alert,
	input wire logic [2:0] seq_state
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	// ==========================================
	// Properties
	wire logic stop_req = commanded_off || !bias_ok || other_fault_shutdown;
	property p_status; $rose(fast_oc_detect) |=> status_fast_oc_fault; endproperty
	property p_alert; $rose(fast_oc_detect) |=> host_alert ##1 !host_alert; endproperty
	property p_run_on; seq_state == 3'h0 |-> output_enable; endproperty
	property p_limit; seq_state == 3'h1 |-> limit_at_fast && output_enable; endproperty
	property p_off; seq_state == 3'h2 |-> !output_enable; endproperty
	property p_held; seq_state == 3'h4 && !fault_clear |=> seq_state == 3'h4 && !output_enable; endproperty
	property p_strobe; restart_strobe |-> ##[0:1] seq_state == 3'h3 ##1 !restart_strobe; endproperty
	property p_stop; stop_req && (seq_state == 3'h2 || seq_state == 3'h3) |-> ##[1:2] seq_state == 3'h4; endproperty

	a_status: assert property (p_status) else $error("status bit not set after fault");
	a_alert: assert property (p_alert) else $error("alert pulse wrong");
	a_run_on: assert property (p_run_on) else $error("output off while running");
	a_limit: assert property (p_limit) else $error("no fast limiting during delay");
	a_off: assert property (p_off) else $error("output on during shutdown wait");
	a_held: assert property (p_held) else $error("left held-off state without clear");
	a_strobe: assert property (p_strobe) else $error("restart strobe without restart");
	a_stop: assert property (p_stop) else $error("retry not stopped");

	c_restart: cover property (restart_strobe);
	c_held: cover property (seq_state == 3'h4);
	c_alert: cover property (host_alert);
endmodule

// File: fast_overcurrent_fault_response.sv
// Fast output over-current fault response sequencer.
// Assumes comparator and control inputs are synchronous to mclk.
// Assumes the fault-clear pulse and the stop levels come from the supervisor.
//
// Functional notes
// - Any response code sets the status fault bit
// - Any response code notifies the host
// - Code 00: run on, limit at normal threshold
// - Code 11: limit at fast threshold for delay
// - Still limiting after delay: shut down, retry
// - Retry 000: no restart, held off until clear
// - Retry 001: exactly one restart attempt
// - Retry 010: exactly two restart attempts
// - Retry 011: exactly three restart attempts
// - All attempts failed: output held off until clear
// - Retry 111: restart attempts without limit
// - Attempt-to-attempt spacing equals the delay
// - Retry 100..110: four to six attempts
// - Delay field n selects 2^n units
// - Unit code selects 1, 4, 16, 256 ms
// - Off command, bias loss, other fault stop retrying
`timescale 1ns/10ps
`include "fast_oc_defines.svh"

module fast_overcurrent_fault_response #(
	parameter int CYCLES_PER_MS = `FOC_CYCLES_PER_MS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Command port for the response setting
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_wdata,
	output logic [7:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_ack,
	// Time unit field from the fault configuration
	input wire logic [1:0] current_fault_time_unit,
	// Power stage sense and control
	input wire logic fast_oc_detect,
	input wire logic current_limiting,
	input wire logic fault_clear,
	input wire logic commanded_off,
	input wire logic bias_ok,
	input wire logic other_fault_shutdown,
	// Outputs to the power stage
	output logic output_enable,
	output logic limit_at_normal,
	output logic limit_at_fast,
	output logic restart_strobe,
	// Status and host notification
	output logic status_fast_oc_fault,
	output logic host_alert,
	output logic [2:0] seq_state
);

	// ==========================================
	// Configuration and timer
	fast_oc_pkg::resp_cfg_s cfg;
	logic timer_start;
	logic timer_done;

	fast_oc_cfg_reg u_cfg (
		.mclk(mclk),
		.reset(reset),
		.cmd_code(cmd_code),
		.cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd),
		.cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata),
		.cmd_rvalid(cmd_rvalid),
		.cmd_ack(cmd_ack),
		.cfg(cfg)
	);

	// A new time unit takes effect at the next start, not mid-delay
	fast_oc_delay_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) u_timer (
		.mclk(mclk),
		.reset(reset),
		.start(timer_start),
		.unit_code(current_fault_time_unit),
		.delay_exp(cfg.delay_exp),
		.done(timer_done)
	);

	// ==========================================
	// State
	fast_oc_pkg::resp_state_e state_r;
	fast_oc_pkg::resp_state_e state_nxt;
	// Remaining restart attempts; not consulted under continuous retry
	logic [2:0] tries_left_r;
	logic [2:0] tries_left_nxt;
	logic detect_d_r;
	logic status_r;
	logic alert_r;
	logic out_en_r;
	logic lim_norm_r;
	logic lim_fast_r;
	logic restart_r;
	logic restart_nxt;

	wire fault_edge;
	wire shut_retry;
	wire ignore_fault;
	wire stop_retry;
	wire retry_none;
	wire retry_always;
	wire more_tries;
	wire [2:0] tries_dec;

	// ==========================================
	// State decoding used by the output controls

	// Output is off while a shutdown is waited out and while held off
	function automatic logic is_output_off(input fast_oc_pkg::resp_state_e st);
		return (st == fast_oc_pkg::ST_OFF_WAIT) || (st == fast_oc_pkg::ST_HELD_OFF);
	endfunction

	// Fast threshold clamps during the delay and during each attempt
	function automatic logic is_fast_limit(input fast_oc_pkg::resp_state_e st);
		return (st == fast_oc_pkg::ST_LIMIT) || (st == fast_oc_pkg::ST_RESTART);
	endfunction

	// Only normal operation lets the ignore-fault codes clamp
	function automatic logic is_running(input fast_oc_pkg::resp_state_e st);
		return st == fast_oc_pkg::ST_RUN;
	endfunction

	// ==========================================
	// Fault and setting decode
	// Edge, not level: a lasting fault must not rerun the sequence
	assign fault_edge = fast_oc_detect && !detect_d_r;
	// Codes 01 and 10 fall back to ignore-fault limiting
	assign shut_retry = (cfg.response == `FOC_RESP_SHUT_RETRY);
	assign ignore_fault = !shut_retry;
	assign stop_retry = commanded_off || !bias_ok || other_fault_shutdown;
	assign retry_none = (cfg.retry == `FOC_RETRY_NONE);
	assign retry_always = (cfg.retry == `FOC_RETRY_ALWAYS);
	// Continuous retry never runs out; others count down to zero
	assign more_tries = retry_always || (tries_left_r != 3'h0);
	// Saturates at zero so an odd sequence can never wrap the count
	assign tries_dec = (tries_left_r == 3'h0) ? 3'h0 : tries_left_r - 3'h1;

	// ==========================================
	// Sequencer
	// One shared timer: each timed phase (limit, off-wait, restart) restarts it, so an old expiry never carries over
	always_comb begin
		state_nxt = state_r;
		tries_left_nxt = tries_left_r;
		timer_start = 1'b0;
		restart_nxt = 1'b0;
		unique case (state_r)
			fast_oc_pkg::ST_RUN: begin
				if (fault_edge && shut_retry) begin
					state_nxt = fast_oc_pkg::ST_LIMIT;
					timer_start = 1'b1;
				end
			end
			fast_oc_pkg::ST_LIMIT: begin
				if (timer_done) begin
					if (!current_limiting) begin
						state_nxt = fast_oc_pkg::ST_RUN;
					end else if (retry_none) begin
						state_nxt = fast_oc_pkg::ST_HELD_OFF;
					end else begin
						state_nxt = fast_oc_pkg::ST_OFF_WAIT;
						tries_left_nxt = cfg.retry;
						timer_start = 1'b1;
					end
				end
			end
			fast_oc_pkg::ST_OFF_WAIT: begin
				// A stop request outranks an expiring wait
				if (stop_retry) begin
					state_nxt = fast_oc_pkg::ST_HELD_OFF;
				end else if (timer_done) begin
					state_nxt = fast_oc_pkg::ST_RESTART;
					restart_nxt = 1'b1;
					timer_start = 1'b1;
					tries_left_nxt = tries_dec;
				end
			end
			fast_oc_pkg::ST_RESTART: begin
				if (stop_retry) begin
					state_nxt = fast_oc_pkg::ST_HELD_OFF;
				end else if (timer_done) begin
					if (!current_limiting) begin
						state_nxt = fast_oc_pkg::ST_RUN;
					end else if (more_tries) begin
						// Next attempt starts one delay after the last one
						restart_nxt = 1'b1;
						timer_start = 1'b1;
						if (!retry_always) begin
							tries_left_nxt = tries_dec;
						end
					end else begin
						state_nxt = fast_oc_pkg::ST_HELD_OFF;
					end
				end
			end
			fast_oc_pkg::ST_HELD_OFF: begin
				// Only a clear releases; stop inputs need no release of their own
				if (fault_clear) begin
					state_nxt = fast_oc_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = fast_oc_pkg::ST_HELD_OFF;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r <= fast_oc_pkg::ST_RUN;
			tries_left_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			tries_left_r <= tries_left_nxt;
		end
	end

	// Resets low like the idle comparator, so no false edge follows reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			detect_d_r <= 1'b0;
		end else begin
			detect_d_r <= fast_oc_detect;
		end
	end

	// One-cycle pulse per attempt, never held across attempts
	always_ff @(posedge mclk) begin
		if (reset) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= restart_nxt;
		end
	end

	// ==========================================
	// Status bit and host notification
	always_ff @(posedge mclk) begin
		if (reset) begin
			status_r <= 1'b0;
		end else begin
			// A new fault in the clearing cycle keeps the bit set
			if (fault_edge) begin
				status_r <= 1'b1;
			end else if (fault_clear) begin
				status_r <= 1'b0;
			end
		end
	end

	// Alert is a pulse per event; the host reads the cause from the status bit
	always_ff @(posedge mclk) begin
		if (reset) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= fault_edge;
		end
	end

	// ==========================================
	// Power stage controls
	// Registered from the next state so each control lines up with seq_state
	wire out_en_nxt;
	wire lim_norm_nxt;
	wire lim_fast_nxt;

	assign out_en_nxt = !is_output_off(state_nxt);
	// Ignore-fault codes clamp at the normal limit for as long as the fault lasts
	assign lim_norm_nxt = ignore_fault && fast_oc_detect && is_running(state_nxt);
	assign lim_fast_nxt = is_fast_limit(state_nxt);

	// Output stays on through reset so start-up is not held back
	always_ff @(posedge mclk) begin
		if (reset) begin
			out_en_r <= 1'b1;
		end else begin
			out_en_r <= out_en_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			lim_norm_r <= 1'b0;
			lim_fast_r <= 1'b0;
		end else begin
			lim_norm_r <= lim_norm_nxt;
			lim_fast_r <= lim_fast_nxt;
		end
	end

	assign output_enable = out_en_r;
	assign limit_at_normal = lim_norm_r;
	assign limit_at_fast = lim_fast_r;
	assign restart_strobe = restart_r;
	assign status_fast_oc_fault = status_r;
	assign host_alert = alert_r;
	assign seq_state = state_r;

endmodule

// File: power_stage_model.sv
// Power stage and load partner: reports current limiting while a short persists and the output is powered.
// Assumes persist is driven by the bench to model a lasting short.
`timescale 1ns/10ps

module power_stage_model (
	// Clock
	input wire logic mclk,
	// Stage control
	input wire logic output_enable,
	input wire logic persist,
	// Sense
	output logic current_limiting
);
	// A short only draws current while the output is switched on
	always_ff @(posedge mclk) begin
		current_limiting <= persist & output_enable;
	end
endmodule

// File: tb_fast_overcurrent_fault_response.sv
// Testbench for the fast over-current fault response block.
// Assumes a shortened millisecond count of 4 cycles.
`timescale 1ns/10ps
`include "fast_oc_defines.svh"

module tb_fast_overcurrent_fault_response;
	localparam int CPM = 4;
	logic mclk = 0, reset = 1, cmd_wr = 0, cmd_rd = 0, fast_oc_detect = 0, fault_clear = 0;
	logic commanded_off = 0, bias_ok = 1, other_fault_shutdown = 0, persist = 0;
	logic [7:0] cmd_code = 8'h00, cmd_wdata = 8'h00, cmd_rdata;
	logic [1:0] tu = 2'h0;
	logic [2:0] seq_state;
	logic cmd_rvalid, cmd_ack, current_limiting, output_enable, limit_at_normal, limit_at_fast;
	logic restart_strobe, status_fast_oc_fault, host_alert;
	logic [7:0] cs [10] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hE8, 8'hF0};
	int err_count = 0, tests_run = 0, cyc = 0;

	always #5 mclk = ~mclk;

	fast_overcurrent_fault_response #(.CYCLES_PER_MS(CPM)) dut_u (.mclk(mclk), .reset(reset),
		.cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_ack(cmd_ack), .current_fault_time_unit(tu),
		.fast_oc_detect(fast_oc_detect), .current_limiting(current_limiting), .fault_clear(fault_clear),
		.commanded_off(commanded_off), .bias_ok(bias_ok), .other_fault_shutdown(other_fault_shutdown),
		.output_enable(output_enable), .limit_at_normal(limit_at_normal), .limit_at_fast(limit_at_fast),
		.restart_strobe(restart_strobe), .status_fast_oc_fault(status_fast_oc_fault),
		.host_alert(host_alert), .seq_state(seq_state));
	power_stage_model stage_u (.mclk(mclk), .output_enable(output_enable), .persist(persist),
		.current_limiting(current_limiting));

	// ==========================================
	// Reporting
	task test_done;
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			test_done();
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// ==========================================
	// Command port access; reads of foreign codes give zero and no ack
	task acc(input logic [7:0] c, input logic w, input logic [7:0] d, input logic [7:0] e);
		@(posedge mclk);
		cmd_code <= c;
		cmd_wdata <= d;
		cmd_wr <= w;
		cmd_rd <= !w;
		@(posedge mclk);
		cmd_wr <= 0;
		cmd_rd <= 0;
		#1;
		chk(cmd_ack, c == `FOC_CFG_CMD);
		if (!w) begin
			chk(cmd_rvalid, 1);
			chk(cmd_rdata, e);
		end
	endtask

	// ==========================================
	// One fault event under setting c, unit code u, lasting short p, stop inputs s
	task fcase(input logic [7:0] c, input logic [1:0] u, input logic p, input logic [2:0] s);
		int um, ll, ns, w, n, l, ks;
		logic [2:0] es;
		um = (u == 0) ? 1 : (u == 1) ? 4 : (u == 2) ? 16 : 256;
		ll = (c[7:6] == 2'h3) ? (um * CPM) << c[2:0] : 0;
		ns = (c[7:6] == 2'h3 && p) ? c[5:3] : 0;
		es = (c[7:6] == 2'h3 && p) ? 3'h4 : 3'h0;
		w = (ll + 4) * (2 * ns + 2) + 8;
		n = 0;
		l = 0;
		ks = 0;
		acc(`FOC_CFG_CMD, 1, c, 0);
		@(posedge mclk);
		tu <= u;
		persist <= p;
		fast_oc_detect <= 1;
		for (int k = 1; k <= w; k++) begin
			@(posedge mclk);
			#1;
			n += (restart_strobe === 1'b1);
			l += (seq_state === 3'h1);
			if (k == 1) begin
				chk(status_fast_oc_fault, 1);
				chk(host_alert, 1);
			end
			if (k == 2) begin
				chk(limit_at_normal, c[7:6] != 2'h3);
				chk(limit_at_fast, c[7:6] == 2'h3);
			end
			// Attempt starts are one delay apart, up to two cycles of hand-over allowed
			if (restart_strobe === 1'b1) begin
				if (n > 1)
					chk(k - ks >= ll && k - ks <= ll + 2, 1);
				ks = k;
			end
		end
		chk(l >= ll && l <= ll + 2, 1);
		if (c[5:3] == 3'h7 && ns > 0) begin
			chk(n >= 7, 1);
			@(posedge mclk);
			{other_fault_shutdown, bias_ok, commanded_off} <= s ^ 3'b010;
			repeat (2 * ll + 8) @(posedge mclk);
			#1;
		end else
			chk(n, ns);
		chk(seq_state, es);
		chk(output_enable, es == 3'h0);
		@(posedge mclk);
		{other_fault_shutdown, bias_ok, commanded_off} <= 3'b010;
		persist <= 0;
		fast_oc_detect <= 0;
		fault_clear <= 1;
		@(posedge mclk);
		fault_clear <= 0;
		repeat (2) @(posedge mclk);
		#1;
		chk(status_fast_oc_fault, 0);
		chk(seq_state, 0);
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		reset <= 0;
		acc(`FOC_CFG_CMD, 0, 0, `FOC_CFG_RESET);
		acc(`FOC_CFG_CMD, 1, 8'hC9, 0);
		acc(8'hCB, 1, 8'hFF, 0);
		acc(8'hCB, 0, 0, 8'h00);
		acc(`FOC_CFG_CMD, 0, 0, 8'hC9);
		for (int i = 0; i < 10; i++)
			fcase(cs[i], 2'h0, 1, 3'b000);
		fcase(8'hC8, 2'h0, 0, 3'b000);
		fcase(8'hC2, 2'h1, 1, 3'b000);
		fcase(8'hC0, 2'h2, 1, 3'b000);
		fcase(8'hC7, 2'h0, 1, 3'b000);
		fcase(8'hC0, 2'h3, 1, 3'b000);
		fcase(8'hF8, 2'h0, 1, 3'b001);
		fcase(8'hF8, 2'h0, 1, 3'b010);
		fcase(8'hF8, 2'h0, 1, 3'b100);
		test_done();
	end
endmodule

bind fast_overcurrent_fault_response fast_oc_properties chk_u (.mclk(mclk), .reset(reset),
	.fast_oc_detect(fast_oc_detect), .fault_clear(fault_clear), .commanded_off(commanded_off),
	.bias_ok(bias_ok), .other_fault_shutdown(other_fault_shutdown), .output_enable(output_enable),
	.limit_at_fast(limit_at_fast), .restart_strobe(restart_strobe),
	.status_fast_oc_fault(status_fast_oc_fault), .host_alert(host_alert), .seq_state(seq_state));
